// ### sssr_consts.svh
// Constants for the serial shift and storage register block
// Notes on behaviour
// - An 8-bit serial-in, parallel-out shift chain feeds a separate 8-bit storage register.
// - The shift chain and the storage register each have their own clock and their own clear, and each clear overrides its clock.
// - Both registers change only on a rising edge of their own clock, apart from the clears.
// - With both clocks tied together, the storage register takes the chain value from before the edge and so trails it by one clock.
// - A serial cascade output taken from the shift chain lets several devices be chained.
// - While shift_clear_n is low every chain stage is held at zero whatever serial_in and shift_clock do.
// - On a rising shift_clock edge with shift_clear_n high, stage one takes serial_in and each later stage takes its predecessor.
// - With shift_clear_n high and no rising shift_clock edge, the chain keeps its contents.
// - While store_clear_n is low the storage register is held at zero whatever store_clock and the chain do.
// - On a rising store_clock edge with store_clear_n high, all chain stages are copied in parallel into the storage register.
// - With store_clear_n high and no rising store_clock edge, the storage register keeps its contents.
`ifndef SSSR_CONSTS_SVH
`define SSSR_CONSTS_SVH

// ****************************************
// Widths and counts
// ****************************************
`define SSSR_WIDTH       8
`define SSSR_SYNC_STAGES 2

// ****************************************
// Reset values
// ****************************************
`define SSSR_CHAIN_RST   8'h00
`define SSSR_STORE_RST   8'h00
`define SSSR_SYNC_RST    1'b0

`endif

// ### sssr_pkg.sv
// Types shared by the serial shift and storage register block
package sssr_pkg;

    // Per-register action for one core clock cycle
    typedef enum logic [2:0] {
        SSSR_HOLD  = 3'b001,
        SSSR_CLEAR = 3'b010,
        SSSR_LOAD  = 3'b100
    } sssr_act_t;

    // Clear wins over a clock edge, edge wins over hold
    function automatic sssr_act_t sssr_decide(input logic clear_n, input logic rise);
        sssr_act_t act;
        act = SSSR_HOLD;
        if (!clear_n) begin
            act = SSSR_CLEAR;
        end else if (rise) begin
            act = SSSR_LOAD;
        end
        return act;
    endfunction : sssr_decide

endpackage : sssr_pkg

// ### sssr_sync.sv
// Multi-flop synchroniser for pin inputs
`include "sssr_consts.svh"
module sssr_sync
    import sssr_pkg::*;
#(
    parameter int WIDTH  = 1,
    parameter int STAGES = `SSSR_SYNC_STAGES
) (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sync_out
);

    // Refused at elaboration: one flop alone leaves metastability on the output
    if (WIDTH < 1 || STAGES < 2) begin : g_bad_param
        $error("sssr_sync: WIDTH must be >= 1 and STAGES >= 2");
    end

    logic [WIDTH-1:0] stage_ff     [STAGES];
    logic [WIDTH-1:0] nxt_stage    [STAGES];

    // Only the next stage reads each flop, and sync_out reads the last; the first is never decoded
    always_comb begin
        nxt_stage[0] = pin_in;
        for (int i = 1; i < STAGES; i++) begin
            nxt_stage[i] = stage_ff[i-1];
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < STAGES; i++) begin
            if (!nrst) begin
                stage_ff[i] <= {WIDTH{`SSSR_SYNC_RST}};
            end else begin
                stage_ff[i] <= nxt_stage[i];
            end
        end
    end

    assign sync_out = stage_ff[STAGES-1];

endmodule : sssr_sync

// ### sssr_rise.sv
// Rising-edge detector for synchronised clock levels
`include "sssr_consts.svh"
module sssr_rise
    import sssr_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] rise_out
);

    if (WIDTH < 1) begin : g_bad_param
        $error("sssr_rise: WIDTH must be >= 1");
    end

    logic [WIDTH-1:0] prev_ff;
    logic [WIDTH-1:0] nxt_prev;

    always_comb begin
        nxt_prev = level_in;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            prev_ff <= {WIDTH{`SSSR_SYNC_RST}};
        end else begin
            prev_ff <= nxt_prev;
        end
    end

    // Reset value low, the idle clock level; a clock already high at release reads as one rise
    assign rise_out = level_in & ~prev_ff;

endmodule : sssr_rise

// ### sssr_top.sv
// Serial shift chain feeding a parallel storage register
`include "sssr_consts.svh"
module sssr_top
    import sssr_pkg::*;
#(
    parameter int WIDTH = `SSSR_WIDTH
) (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic             serial_in,
    input  wire logic             shift_clock,
    input  wire logic             shift_clear_n,
    input  wire logic             store_clock,
    input  wire logic             store_clear_n,
    output logic      [WIDTH-1:0] parallel_outputs,
    output logic                  cascade_out
);

    if (WIDTH < 2) begin : g_bad_param
        $error("sssr_top: WIDTH must be >= 2");
    end

    // ****************************************
    // Pin synchronisation
    // ****************************************
    // Data and clocks share one synchroniser so they keep their relative timing
    logic [4:0] pins_sync;
    logic [1:0] clk_rise;
    logic       data_s;
    logic       shift_clr_n_s;
    logic       store_clr_n_s;

    sssr_sync #(
        .WIDTH  (5),
        .STAGES (`SSSR_SYNC_STAGES)
    ) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pin_in   ({store_clear_n, shift_clear_n, store_clock, shift_clock, serial_in}),
        .sync_out (pins_sync)
    );

    sssr_rise #(
        .WIDTH (2)
    ) u_rise (
        .core_clk (core_clk),
        .nrst     (nrst),
        .level_in (pins_sync[2:1]),
        .rise_out (clk_rise)
    );

    assign data_s        = pins_sync[0];
    assign shift_clr_n_s = pins_sync[3];
    assign store_clr_n_s = pins_sync[4];

    // ****************************************
    // Shift chain
    // ****************************************
    logic [WIDTH-1:0] chain_ff;
    logic [WIDTH-1:0] nxt_chain;
    logic [WIDTH-1:0] chain_shifted;
    sssr_act_t        shift_act;

    assign chain_shifted[0] = data_s;
    for (genvar i = 1; i < WIDTH; i++) begin : g_shift
        assign chain_shifted[i] = chain_ff[i-1];
    end

    always_comb begin
        shift_act = sssr_decide(shift_clr_n_s, clk_rise[0]);
        nxt_chain = chain_ff;
        unique case (shift_act)
            SSSR_CLEAR: begin
                nxt_chain = WIDTH'(`SSSR_CHAIN_RST);
            end
            SSSR_LOAD: begin
                nxt_chain = chain_shifted;
            end
            SSSR_HOLD: begin
                nxt_chain = chain_ff;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            chain_ff <= WIDTH'(`SSSR_CHAIN_RST);
        end else begin
            chain_ff <= nxt_chain;
        end
    end

    // ****************************************
    // Storage register
    // ****************************************
    logic [WIDTH-1:0] store_ff;
    logic [WIDTH-1:0] nxt_store;
    sssr_act_t        store_act;

    always_comb begin
        store_act = sssr_decide(store_clr_n_s, clk_rise[1]);
        nxt_store = store_ff;
        unique case (store_act)
            SSSR_CLEAR: begin
                nxt_store = WIDTH'(`SSSR_STORE_RST);
            end
            SSSR_LOAD: begin
                // Takes the pre-edge chain, so tied clocks leave it one step behind
                nxt_store = chain_ff;
            end
            SSSR_HOLD: begin
                nxt_store = store_ff;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            store_ff <= WIDTH'(`SSSR_STORE_RST);
        end else begin
            store_ff <= nxt_store;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign parallel_outputs = store_ff;
    assign cascade_out      = chain_ff[WIDTH-1];

endmodule : sssr_top

// ### sssr_asserts.sv
// Checker for the serial shift and storage register
module sssr_asserts
#(
    parameter int WIDTH = 8
) (
    input wire logic             core_clk,
    input wire logic             nrst,
    input wire logic             serial_in,
    input wire logic             shift_clock,
    input wire logic             shift_clear_n,
    input wire logic             store_clock,
    input wire logic             store_clear_n,
    input wire logic [WIDTH-1:0] parallel_outputs,
    input wire logic             cascade_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [WIDTH-1:0] chain_ff;
    logic [WIDTH-1:0] store_ff;
    logic             sck_ff;
    logic             rck_ff;
    logic             last_w;
    assign last_w = chain_ff[WIDTH-1];
    // Runs two cycles ahead: no synchronisers
    always_ff @(posedge core_clk) begin
        // Synchronisers reset low, so a clock high at release counts as a rise
        sck_ff <= nrst && shift_clock;
        rck_ff <= nrst && store_clock;
        if (!nrst || !shift_clear_n) chain_ff <= '0;
        else if (shift_clock && !sck_ff) chain_ff <= {chain_ff[WIDTH-2:0], serial_in};
        if (!nrst || !store_clear_n) store_ff <= '0;
        else if (store_clock && !rck_ff) store_ff <= chain_ff;
    end
    // ****
    // Properties
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_cascade_model: assert property (cascade_out == $past(last_w, 2))
        else $error("cascade output wrong");
    a_store_model: assert property (parallel_outputs == $past(store_ff, 2))
        else $error("parallel outputs wrong");
    a_shift_clear: assert property (!shift_clear_n |-> ##3 !cascade_out)
        else $error("chain not cleared");
    a_store_clear: assert property (!store_clear_n |-> ##3 parallel_outputs == '0)
        else $error("storage not cleared");
    a_shift_hold: assert property (!$rose(shift_clock) && shift_clear_n |-> ##3 $stable(cascade_out))
        else $error("chain moved without edge");
    a_store_hold: assert property (!$rose(store_clock) && store_clear_n |-> ##3 $stable(parallel_outputs))
        else $error("storage moved without edge");
    a_store_trail: assert property ($rose(store_clock) && store_clear_n |-> ##3 parallel_outputs[WIDTH-1] == $past(cascade_out))
        else $error("storage not from chain");
    a_clear_wins: assert property ($rose(shift_clock) && !shift_clear_n |-> ##3 !cascade_out)
        else $error("clock beat clear");
endmodule : sssr_asserts

bind sssr_top sssr_asserts #(.WIDTH(WIDTH)) i_chk (.core_clk, .nrst, .serial_in, .shift_clock, .shift_clear_n,
    .store_clock, .store_clear_n, .parallel_outputs, .cascade_out);

// ### sssr_host.sv
// Host pin driver for the shift and storage register
module sssr_host (
    input  wire logic core_clk,
    output logic      serial_in,
    output logic      shift_clock,
    output logic      shift_clear_n,
    output logic      store_clock,
    output logic      store_clear_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {serial_in, shift_clock, store_clock} = 3'h0;
        {shift_clear_n, store_clear_n} = 2'h3;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : cyc
    // Two cycles per phase so no edge slips between samples
    task automatic send(input logic [7:0] d, input logic tie, input logic clr);
        shift_clear_n = !clr;
        for (int i = 7; i >= 0; i--) begin
            serial_in = d[i];
            cyc(2);
            shift_clock = 1'b1;
            store_clock = tie;
            cyc(2);
            {shift_clock, store_clock} = 2'h0;
            cyc(1);
            serial_in = !d[i];
            cyc(1);
        end
        shift_clear_n = 1'b1;
    endtask : send
    task automatic store();
        store_clock = 1'b1;
        cyc(2);
        store_clock = 1'b0;
        cyc(2);
    endtask : store
    // A store clock rise inside the clear must lose to the clear
    task automatic clear_store();
        store_clear_n = 1'b0;
        cyc(1);
        store_clock = 1'b1;
        cyc(2);
        store_clock = 1'b0;
        store_clear_n = 1'b1;
        cyc(3);
    endtask : clear_store
endmodule : sssr_host

// ### sssr_tb_top.sv
// Self-checking testbench for the shift and storage register
module sssr_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       core_clk = 1'b0;
    logic       nrst     = 1'b0;
    logic       serial_in;
    logic       shift_clock;
    logic       shift_clear_n;
    logic       store_clock;
    logic       store_clear_n;
    logic [7:0] parallel_outputs;
    logic       cascade_out;
    logic [8:0] notes[$];
    logic [8:0] exp;
    logic [7:0] d;
    logic [7:0] e;
    int         failures = 0;
    int         compares = 0;
    event       chk_ev;

    always #20 core_clk = ~core_clk;

    sssr_host i_host (.core_clk, .serial_in, .shift_clock, .shift_clear_n, .store_clock, .store_clear_n);
    sssr_top #(.WIDTH(8)) i_dut (.core_clk, .nrst, .serial_in, .shift_clock, .shift_clear_n, .store_clock,
        .store_clear_n, .parallel_outputs, .cascade_out);

    task automatic note(input logic [8:0] v);
        notes.push_back(v);
        -> chk_ev;
        i_host.cyc(1);
    endtask : note

    always @(chk_ev) begin
        exp = notes.pop_front();
        compares++;
        if ({cascade_out, parallel_outputs} !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, {cascade_out, parallel_outputs}, exp);
        end
    end

    task automatic print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (50000) @(posedge core_clk);
        failures++;
        print_verdict();
    end

    initial begin
        void'($urandom(19));
        i_host.cyc(16);
        nrst = 1'b1;
        i_host.cyc(4);
        note(9'h000);
        for (int n = 0; n < 6; n++) begin
            d = 8'($urandom());
            i_host.send(d, 1'b0, 1'b0);
            i_host.store();
            note({d[7], d});
        end
        i_host.clear_store();
        note({d[7], 8'h00});
        e = 8'($urandom());
        i_host.send(e, 1'b0, 1'b1);
        i_host.store();
        note(9'h000);
        d = 8'($urandom());
        i_host.send(d, 1'b1, 1'b0);
        note({d[7], 1'b0, d[7:1]});
        e = 8'($urandom());
        i_host.send(e, 1'b0, 1'b0);
        note({e[7], 1'b0, d[7:1]});
        nrst = 1'b0;
        i_host.cyc(3);
        note(9'h000);
        nrst = 1'b1;
        i_host.cyc(4);
        print_verdict();
    end
endmodule : sssr_tb_top
